// [hw/cfg_cmd.sv]
// configuration and inquiry command interpreter with bus-master handshake
// assumes the host writes commands and reads results over the register port
// Summary of operation
// - opcode 06: four bytes, 00 off, 01 on
// - time-out is 16-bit ms, byte two high
// - done always; rejected on bad byte0/byte1
// - opcode 07: tenure 2..15 us, default 7; code also accepts 0 and 1
// - tenure above 15 sets rejected flag
// - request bus, wait acknowledge, then transfer
// - on preempt release within programmed tenure
// - opcodes 08 and 09 take one byte, no effect
// - opcode 0A: eight bytes, LUN bit per target
// - own ID byte zero; done after eight
// - opcode 0B: DMA and interrupt one-hot bytes
// - third config byte is own ID, upper zero
// - reported DMA channel is a configurable option
// - opcode 0D: send exactly the requested count
// - each result byte flagged ready, host reads
//
// Our own choices: the strobed register port and the register addresses.
module cfg_cmd
	import cfg_cmd_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic [63:0] LUN_MAP,
	input wire logic [2:0] OWN_ID,
	input wire logic [1:0] DMA_SEL,
	input wire logic [7:0] IRQ_ONEHOT,
	input wire logic [127:0] SETUP_INFO,
	input wire logic MASTER_ACK,
	output logic MASTER_REQ,
	output logic [15:0] SEL_TIMEOUT_MS,
	output logic SEL_TIMEOUT_EN,
	output logic IRQ
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PARAM = 2'b01,
		ST_REPLY = 2'b10
	} cmd_state_t;
	typedef enum logic [1:0] {
		BS_IDLE = 2'b00,
		BS_WAIT = 2'b01,
		BS_OWN = 2'b10,
		BS_PREEMPT = 2'b11
	} bus_state_t;

	cmd_state_t state_q;
	logic [7:0] opcode_q;
	logic [7:0] pcnt_q;      // parameter bytes still expected
	logic [7:0] pidx_q;      // parameter byte index
	logic [7:0] p0_q;
	logic [7:0] p1_q;
	logic [7:0] p2_q;
	logic [7:0] rlen_q;      // result bytes to send
	logic [7:0] ridx_q;      // next result byte index
	logic [7:0] dout_q;
	logic ready_q;
	logic [S_W-1:0] stat_q;
	logic [S_W-1:0] mask_q;
	logic [15:0] sel_ms_q;
	logic sel_en_q;
	logic [7:0] preempt_q;
	logic [7:0] rdata_q;
	logic irq_q;
	bus_state_t bus_q;
	logic [7:0] us_left_q;
	logic [7:0] tick_q;
	logic ack_s1_q;
	logic ack_s2_q;
	logic bus_start_q;

	logic cmd_wr;
	logic data_rd;
	logic set_done;
	logic set_reject;
	logic [7:0] next_byte;
	logic [7:0] dev_byte;
	logic [7:0] cfg_byte;
	logic [7:0] dma_byte;
	logic [7:0] setup_byte;

	assign cmd_wr = WR && (ADDR == A_CMD);
	assign data_rd = RD && (ADDR == A_DATA) && ready_q;

	// -------------------------------------------------------------
	// result byte selection
	// -------------------------------------------------------------
	// own target byte forced to zero
	always_comb begin
		dev_byte = LUN_MAP[ridx_q[2:0]*8 +: 8];
		if (ridx_q[2:0] == OWN_ID) begin
			dev_byte = 8'h00;
		end
	end

	// reported channel option: 0 none, 1..3 channel 5..7
	always_comb begin
		unique case (DMA_SEL)
			2'b00: dma_byte = 8'h00;
			2'b01: dma_byte = 8'h20;
			2'b10: dma_byte = 8'h40;
			2'b11: dma_byte = 8'h80;
		endcase
	end

	// configuration reply bytes
	always_comb begin
		cfg_byte = 8'h00;
		if (ridx_q == 8'h00) begin
			cfg_byte = dma_byte;
		end else if (ridx_q == 8'h01) begin
			cfg_byte = IRQ_ONEHOT & 8'h6F;
		end else begin
			cfg_byte = {5'h00, OWN_ID};
		end
	end

	// setup bytes past sixteen read as zero
	always_comb begin
		setup_byte = 8'h00;
		if (ridx_q < SETUP_LEN) begin
			setup_byte = SETUP_INFO[ridx_q[3:0]*8 +: 8];
		end
	end

	always_comb begin
		next_byte = setup_byte;
		if (opcode_q == OP_INQ_DEVICES) begin
			next_byte = dev_byte;
		end else if (opcode_q == OP_INQ_CONFIG) begin
			next_byte = cfg_byte;
		end
	end

	// -------------------------------------------------------------
	// command sequencer
	// -------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		set_done <= 1'b0;
		set_reject <= 1'b0;
		if (!NRST) begin
			state_q <= ST_IDLE;
			opcode_q <= 8'h00;
			pcnt_q <= 8'h00;
			pidx_q <= 8'h00;
			p0_q <= 8'h00;
			p1_q <= 8'h00;
			p2_q <= 8'h00;
			rlen_q <= 8'h00;
			ridx_q <= 8'h00;
			dout_q <= 8'h00;
			ready_q <= 1'b0;
			sel_ms_q <= SEL_MS_RST;
			sel_en_q <= 1'b1;
			preempt_q <= PREEMPT_US_RST;
			set_done <= 1'b0;
			set_reject <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (cmd_wr) begin
						opcode_q <= WDATA;
						pidx_q <= 8'h00;
						ridx_q <= 8'h00;
						if (WDATA == OP_SEL_TIMEOUT) begin
							pcnt_q <= 8'h04;
							state_q <= ST_PARAM;
						end else if (WDATA == OP_PREEMPT_TIME || WDATA == OP_TIME_OFF
							|| WDATA == OP_XFER_RATE || WDATA == OP_INQ_SETUP) begin
							pcnt_q <= 8'h01;
							state_q <= ST_PARAM;
						end else if (WDATA == OP_INQ_DEVICES || WDATA == OP_INQ_CONFIG) begin
							rlen_q <= (WDATA == OP_INQ_DEVICES) ? DEVICES_LEN : CONFIG_LEN;
							state_q <= ST_REPLY;
						end else begin
							set_done <= 1'b1;
							set_reject <= 1'b1;
						end
					end
				end
				ST_PARAM: begin
					if (cmd_wr) begin
						pidx_q <= pidx_q + 8'h01;
						pcnt_q <= pcnt_q - 8'h01;
						if (pidx_q == 8'h00) p0_q <= WDATA;
						if (pidx_q == 8'h01) p1_q <= WDATA;
						if (pidx_q == 8'h02) p2_q <= WDATA;
						if (pcnt_q == 8'h01) begin
							state_q <= ST_IDLE;
							if (opcode_q == OP_SEL_TIMEOUT) begin
								set_done <= 1'b1;
								if ((p0_q != SEL_OFF && p0_q != SEL_ON) || p1_q != 8'h00) begin
									set_reject <= 1'b1;
								end else begin
									sel_en_q <= (p0_q == SEL_ON);
									sel_ms_q <= {p2_q, WDATA};
								end
							end else if (opcode_q == OP_PREEMPT_TIME) begin
								set_done <= 1'b1;
								if (WDATA > PREEMPT_US_MAX) begin
									set_reject <= 1'b1;
								end else begin
									preempt_q <= WDATA;
								end
							end else if (opcode_q == OP_INQ_SETUP) begin
								rlen_q <= WDATA;
								if (WDATA == 8'h00) begin
									set_done <= 1'b1;
								end else begin
									state_q <= ST_REPLY;
								end
							end else begin
								set_done <= 1'b1;
							end
						end
					end
				end
				ST_REPLY: begin
					// offer one byte, wait for it to be read
					if (!ready_q) begin
						dout_q <= next_byte;
						ready_q <= 1'b1;
						ridx_q <= ridx_q + 8'h01;
					end else if (data_rd) begin
						ready_q <= 1'b0;
						if (ridx_q == rlen_q) begin
							set_done <= 1'b1;
							state_q <= ST_IDLE;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// -------------------------------------------------------------
	// bus-master request and preemption
	// -------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			ack_s1_q <= MASTER_ACK;
			ack_s2_q <= ack_s1_q;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			bus_start_q <= 1'b0;
		end else begin
			bus_start_q <= WR && (ADDR == A_BUSREQ) && WDATA[0];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			bus_q <= BS_IDLE;
			us_left_q <= 8'h00;
			tick_q <= 8'h00;
		end else begin
			unique case (bus_q)
				BS_IDLE: begin
					if (bus_start_q) bus_q <= BS_WAIT;
				end
				BS_WAIT: begin
					if (ack_s2_q) bus_q <= BS_OWN;
				end
				BS_OWN: begin
					if (!ack_s2_q) begin
						bus_q <= BS_PREEMPT;
						us_left_q <= (preempt_q > 8'h01) ? preempt_q - 8'h01 : 8'h01; // no wrap
						tick_q <= 8'h00;
					end
				end
				BS_PREEMPT: begin
					// release before programmed tenure runs out
					if (tick_q == 8'(US_CYCLES - 1)) begin
						tick_q <= 8'h00;
						if (us_left_q <= 8'h01) begin
							bus_q <= BS_IDLE;
						end else begin
							us_left_q <= us_left_q - 8'h01;
						end
					end else begin
						tick_q <= tick_q + 8'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			MASTER_REQ <= 1'b0;
		end else begin
			MASTER_REQ <= (bus_q == BS_WAIT) || (bus_q == BS_OWN);
		end
	end

	// -------------------------------------------------------------
	// status, mask, interrupt
	// -------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			stat_q <= '0;
			mask_q <= '0;
		end else begin
			// set wins over write-one clear
			stat_q <= (stat_q & ~((WR && ADDR == A_STAT) ? WDATA[S_W-1:0] : '0))
				| {(bus_q == BS_PREEMPT) && (tick_q == 8'(US_CYCLES - 1))
					&& (us_left_q <= 8'h01),
					(state_q == ST_REPLY) && !ready_q, set_reject, set_done};
			if (WR && ADDR == A_MASK) mask_q <= WDATA[S_W-1:0];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_q & mask_q);
		end
	end

	// -------------------------------------------------------------
	// register read port
	// -------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			rdata_q <= 8'h00;
		end else if (RD) begin
			unique case (ADDR)
				A_DATA: rdata_q <= dout_q;
				A_STAT: rdata_q <= {3'h0, ready_q, stat_q};
				A_MASK: rdata_q <= {4'h0, mask_q};
				A_SELTO: rdata_q <= sel_ms_q[7:0];
				A_PREEMPT: rdata_q <= preempt_q;
				A_BUSREQ: rdata_q <= {6'h00, bus_q};
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign RDATA = rdata_q;
	assign IRQ = irq_q;
	assign SEL_TIMEOUT_MS = sel_ms_q;
	assign SEL_TIMEOUT_EN = sel_en_q;
endmodule : cfg_cmd

// [hw/cfg_cmd_pkg.sv]
// constants for the adapter configuration command interpreter
// assumes one system clock at 25 MHz and a synchronous active-low reset
package cfg_cmd_pkg;
	// -------------------------------------------------------------
	// clock and timing
	// -------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int US_CYCLES = CLK_HZ / 1000000; // cycles per microsecond
	// -------------------------------------------------------------
	// opcodes
	// -------------------------------------------------------------
	localparam logic [7:0] OP_SEL_TIMEOUT = 8'h06;
	localparam logic [7:0] OP_PREEMPT_TIME = 8'h07;
	localparam logic [7:0] OP_TIME_OFF = 8'h08;
	localparam logic [7:0] OP_XFER_RATE = 8'h09;
	localparam logic [7:0] OP_INQ_DEVICES = 8'h0A;
	localparam logic [7:0] OP_INQ_CONFIG = 8'h0B;
	localparam logic [7:0] OP_INQ_SETUP = 8'h0D;
	// -------------------------------------------------------------
	// parameter values and reset defaults
	// -------------------------------------------------------------
	localparam logic [7:0] SEL_OFF = 8'h00;
	localparam logic [7:0] SEL_ON = 8'h01;
	localparam logic [15:0] SEL_MS_RST = 16'h00FA; // 250 ms
	localparam logic [7:0] PREEMPT_US_RST = 8'h07;
	localparam logic [7:0] PREEMPT_US_MAX = 8'h0F;
	localparam logic [7:0] DEVICES_LEN = 8'h08;
	localparam logic [7:0] CONFIG_LEN = 8'h03;
	localparam logic [7:0] SETUP_LEN = 8'h10;
	// -------------------------------------------------------------
	// software register offsets (word addresses)
	// -------------------------------------------------------------
	localparam logic [3:0] A_CMD = 4'h0;    // write opcode / parameter
	localparam logic [3:0] A_DATA = 4'h1;   // read result byte
	localparam logic [3:0] A_STAT = 4'h2;   // status flags, write one clears
	localparam logic [3:0] A_MASK = 4'h3;   // interrupt mask
	localparam logic [3:0] A_SELTO = 4'h4;  // selection time-out read back
	localparam logic [3:0] A_PREEMPT = 4'h5; // preempt tenure read back
	localparam logic [3:0] A_BUSREQ = 4'h6; // bit 0 starts a bus transfer
	// status bit positions
	localparam int S_DONE = 0;
	localparam int S_REJECT = 1;
	localparam int S_READY = 2;
	localparam int S_BUS_DONE = 3;
	localparam int S_W = 4;
endpackage : cfg_cmd_pkg

// [tb/arb_model.sv]
// host bus arbiter model
// assumes the bench drives preempt after a clock edge
module arb_model #(
	parameter int DLY = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req,
	input wire logic preempt,
	output logic ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q;
	// grant after a delay, withdraw on preempt or drop
	always_ff @(posedge clk) begin
		if (!rst_n || !req || preempt) begin
			ack <= 1'b0;
			cnt_q <= 4'h0;
		end else if (cnt_q == DLY[3:0]) begin
			ack <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule : arb_model

// [tb/cfg_cmd_chk.sv]
// port checker for the command interpreter
// assumes one clock domain, bound below
module cfg_chk
	import cfg_cmd_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic MASTER_ACK,
	input wire logic MASTER_REQ,
	input wire logic [15:0] SEL_TIMEOUT_MS,
	input wire logic SEL_TIMEOUT_EN,
	input wire logic IRQ
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!NRST);
	// ----------------
	// sequences
	// ----------------
	sequence bus_start_s;
		WR && ADDR == A_BUSREQ && WDATA[0];
	endsequence
	sequence preempt_s;
		MASTER_REQ && $fell(MASTER_ACK);
	endsequence
	sequence mask_off_s;
		WR && ADDR == A_MASK && WDATA[3:0] == 4'h0 ##1 !(WR && ADDR == A_MASK);
	endsequence
	// port relations
	rd_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data not idle");
	sel_reset_a: assert property ($rose(NRST) |-> SEL_TIMEOUT_MS == SEL_MS_RST && SEL_TIMEOUT_EN)
		else $error("time-out default wrong");
	sel_hold_a: assert property (!WR [*5] |=> $stable(SEL_TIMEOUT_MS) && $stable(SEL_TIMEOUT_EN))
		else $error("time-out moved without write");
	selto_read_a: assert property (RD && ADDR == A_SELTO |=> RDATA == SEL_TIMEOUT_MS[7:0])
		else $error("time-out read back wrong");
	tenure_read_a: assert property (RD && ADDR == A_PREEMPT |=> RDATA <= 8'h0F && RDATA >= 8'h02)
		else $error("tenure out of range");
	req_start_a: assert property (bus_start_s |-> ##[1:3] MASTER_REQ)
		else $error("bus request missing");
	preempt_release_a: assert property (preempt_s |-> ##[1:375] !MASTER_REQ)
		else $error("bus not released");
	mask_quiet_a: assert property (mask_off_s |=> !IRQ)
		else $error("masked interrupt high");
endmodule : cfg_chk
bind cfg_cmd cfg_chk chk_i (.*);

// [tb/tb.sv]
// self-checking bench for the command interpreter
// assumes design, checker and arbiter model compiled first
module tb
	import cfg_cmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_SYS = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, pre = 1'b0;
	logic MASTER_ACK, MASTER_REQ, SEL_TIMEOUT_EN, IRQ;
	logic [1:0] DMA_SEL = 2'h0;
	logic [2:0] OWN_ID;
	logic [3:0] ADDR = 4'h0;
	logic [7:0] WDATA = 8'h00, RDATA, IRQ_ONEHOT, s, d;
	logic [7:0] t7[3] = '{8'h0F, 8'h10, 8'h02};
	logic [15:0] SEL_TIMEOUT_MS, lf = 16'h001F;
	logic [31:0] t6[5];
	logic [63:0] LUN_MAP;
	logic [127:0] SETUP_INFO;
	int n_mismatch = 0, num_checks = 0, ms = 250, en = 1, ten = 7, n, q[$];
	int tc[3] = '{0, 3, 20};
	cfg_cmd dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .LUN_MAP(LUN_MAP), .OWN_ID(OWN_ID), .DMA_SEL(DMA_SEL),
		.IRQ_ONEHOT(IRQ_ONEHOT), .SETUP_INFO(SETUP_INFO), .MASTER_ACK(MASTER_ACK),
		.MASTER_REQ(MASTER_REQ), .SEL_TIMEOUT_MS(SEL_TIMEOUT_MS),
		.SEL_TIMEOUT_EN(SEL_TIMEOUT_EN), .IRQ(IRQ));
	arb_model #(.DLY(3)) arb (.clk(CLK_SYS), .rst_n(NRST), .req(MASTER_REQ),
		.preempt(pre), .ack(MASTER_ACK));
	// 25 MHz clock
	initial begin
		forever #20 CLK_SYS = ~CLK_SYS;
	end
	// ----------------
	// helpers
	// ----------------
	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction : rnd
	task automatic give_verdict();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (e !== g) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(int c);
		repeat (c) @(posedge CLK_SYS);
	endtask : cyc
	task automatic wr(logic [3:0] a, logic [7:0] v);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		cyc(1);
		WR <= 1'b0;
		cyc(1);
	endtask : wr
	task automatic rd(logic [3:0] a, output logic [7:0] v);
		ADDR <= a;
		RD <= 1'b1;
		cyc(1);
		RD <= 1'b0;
		cyc(1);
		v = RDATA;
	endtask : rd
	task automatic cmd(logic [7:0] op, int c, logic [31:0] p);
		wr(A_CMD, op);
		for (int i = 0; i < c; i++) begin
			wr(A_CMD, p[8*i+:8]);
		end
	endtask : cmd
	task automatic st(logic [1:0] e);
		cyc(3);
		rd(A_STAT, s);
		chk("status", e, s[1:0]);
		chk("irq masked", 0, IRQ);
		wr(A_STAT, 8'h0F);
	endtask : st
	task automatic reply(int c);
		for (int k = 0; k < c; k++) begin
			s = 8'h00;
			for (int i = 0; i < 30 && s[4] !== 1'b1; i++) begin
				rd(A_STAT, s);
			end
			chk("early done", 0, s[0]);
			if (s[4] !== 1'b1) begin
				n_mismatch++;
				give_verdict();
			end
			rd(A_DATA, d);
			chk("result", q.pop_front(), d);
		end
		st(2'h1);
	endtask : reply
	// ----------------
	// main sequence
	// ----------------
	initial begin
		OWN_ID <= 3'(rnd());
		IRQ_ONEHOT <= 8'(rnd());
		LUN_MAP <= {rnd(), rnd(), rnd(), rnd()};
		for (int i = 0; i < 8; i++) begin
			SETUP_INFO[16*i+:16] <= rnd();
		end
		t6 = '{32'h3412_0001, 32'h3412_0000, 32'h2, 32'h0501, {rnd(), 16'h1}};
		cyc(8);
		NRST <= 1'b1;
		cyc(1);
		chk("sel en", en, SEL_TIMEOUT_EN);
		// selection time-out, good and bad bytes
		foreach (t6[i]) begin
			cmd(8'h06, 4, t6[i]);
			n = t6[i][7:0] > 1 || t6[i][15:8] != 0;
			st(2'(n * 2 + 1));
			if (n == 0) begin
				en = t6[i][0];
				ms = {t6[i][23:16], t6[i][31:24]};
			end
			chk("sel ms", ms, SEL_TIMEOUT_MS);
			chk("sel en", en, SEL_TIMEOUT_EN);
		end
		// preempt tenure, default then range
		rd(A_PREEMPT, d);
		chk("tenure", ten, d);
		foreach (t7[i]) begin
			cmd(8'h07, 1, t7[i]);
			n = t7[i] > 15;
			st(2'(n * 2 + 1));
			ten = n ? ten : t7[i];
			rd(A_PREEMPT, d);
			chk("tenure", ten, d);
		end
		// no-effect opcodes
		for (int op = 8; op < 10; op++) begin
			cmd(8'(op), 1, 32'(rnd()));
			st(2'h1);
			chk("sel ms", ms, SEL_TIMEOUT_MS);
		end
		// inquiries
		cmd(8'h0A, 0, 0);
		for (int t = 0; t < 8; t++) begin
			q.push_back(t == OWN_ID ? 0 : LUN_MAP[8*t+:8]);
		end
		reply(8);
		for (int m = 0; m < 4; m++) begin
			DMA_SEL <= 2'(m);
			cmd(8'h0B, 0, 0);
			q = '{m ? 8'h10 << m : 0, IRQ_ONEHOT & 8'h6F, OWN_ID};
			reply(3);
		end
		foreach (tc[i]) begin
			cmd(8'h0D, 1, tc[i]);
			for (int k = 0; k < tc[i]; k++) begin
				q.push_back(k < 16 ? SETUP_INFO[8*k+:8] : 0);
			end
			reply(tc[i]);
		end
		// interrupt raise, mask, clear
		wr(A_MASK, 8'h01);
		rd(A_MASK, d);
		chk("mask", 1, d);
		cmd(8'h08, 1, 0);
		cyc(4);
		chk("irq", 1, IRQ);
		wr(A_MASK, 8'h00);
		cyc(2);
		chk("irq", 0, IRQ);
		wr(A_STAT, 8'h0F);
		rd(4'hF, d);
		chk("unmapped", 0, d);
		// bus grant then preempt
		wr(A_BUSREQ, 8'h01);
		for (n = 0; n < 40 && MASTER_ACK !== 1'b1; n++) begin
			cyc(1);
		end
		if (n == 40) begin
			n_mismatch++;
			give_verdict();
		end
		chk("request", 1, MASTER_REQ);
		pre <= 1'b1;
		for (n = 0; n < 400 && MASTER_REQ !== 1'b0; n++) begin
			cyc(1);
		end
		if (n == 400) begin
			n_mismatch++;
			give_verdict();
		end
		chk("release", 1, n <= ten * US_CYCLES);
		pre <= 1'b0;
		// released status must be up once the tenure has run out
		cyc(ten * US_CYCLES);
		rd(A_STAT, s);
		chk("bus done", 1, s[3]);
		give_verdict();
	end
endmodule : tb
